// File: canir_pkg.sv
package canir_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NMOD = 2;
    localparam int NOBJ = 32;
    localparam int NLINE = 4;
    localparam int AW = 7;
    localparam int DW = 16;

    // ------------------------------------------------------------
    // Device register map (word index on the local port)
    // ------------------------------------------------------------
    localparam logic [3:0] R_CTRL = 4'h0;
    localparam logic [3:0] R_STAT = 4'h1;
    localparam logic [3:0] R_INTID = 4'h2;
    localparam logic [3:0] R_IF1_MASK = 4'h3;
    localparam logic [3:0] R_IF1_REQ = 4'h4;
    localparam logic [3:0] R_IF1_DATA = 4'h5;
    localparam logic [3:0] R_IF2_MASK = 4'h6;
    localparam logic [3:0] R_IF2_REQ = 4'h7;
    localparam logic [3:0] R_IF2_DATA = 4'h8;
    localparam int A_GLOBAL = 6;
    localparam int A_MODSEL = 4;
    localparam logic [6:0] A_SEL0 = 7'h40;
    localparam logic [6:0] A_LINE_CTRL = 7'h44;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int C_INIT = 0;
    localparam int C_IE = 1;
    localparam int C_SIE = 2;
    localparam int C_EIE = 3;
    localparam int S_LEC = 0;
    localparam int S_TRANSMIT_OK_FLAG = 3;
    localparam int S_RECEIVE_OK_FLAG = 4;
    localparam int S_ERROR_WARNING_FLAG = 5;
    localparam int S_BUS_OFF_FLAG = 6;
    localparam int M_NEW_DATA_FLAG = 2;
    localparam int M_CLRPND = 3;
    localparam int M_CTRL = 4;
    localparam int M_WR = 7;
    localparam int O_VALID = 0;
    localparam int O_DIR = 1;
    localparam int O_OBJECT_TX_INT_ENABLE = 2;
    localparam int O_OBJECT_RX_INT_ENABLE = 3;
    localparam int O_PEND = 4;
    localparam int O_NEW_DATA_FLAG = 5;
    localparam int SEL_EN = 8;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RST = 16'h0001;
    localparam logic [15:0] STAT_RST = 16'h0000;
    localparam logic [15:0] SEL_RST = 16'h0000;
    localparam logic [15:0] INTID_NONE = 16'h0000;
    localparam logic [15:0] INTID_STATUS = 16'h8000;
    localparam logic [2:0] LEC_UNUSED = 3'h7;
    localparam logic [8:0] ERR_WARN_LIMIT = 9'h060;
    localparam logic [8:0] BUS_OFF_FLAG_LIMIT = 9'h0FF;
    // Module sources per line: line0 mod0, line1 mod1, line3 both
    localparam logic [NLINE-1:0][NMOD-1:0] LINE_MAP =
        {2'h3, 2'h0, 2'h2, 2'h1};

    // ------------------------------------------------------------
    // Host APB map
    // ------------------------------------------------------------
    localparam logic [11:0] H_CMD = 12'h000;
    localparam logic [11:0] H_WDATA = 12'h004;
    localparam logic [11:0] H_RDATA = 12'h008;
    localparam logic [11:0] H_STAT = 12'h00C;
    localparam logic [11:0] H_LINES = 12'h010;
    localparam int H_CMD_WR = 8;

endpackage

// File: canir_if.sv
`timescale 1ns/1ps
interface canir_if
    import canir_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn
);
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic ack;
    logic [NLINE-1:0] line_irq;

    modport dev (
        input pclk,
        input presetn,
        input req,
        input we,
        input addr,
        input wdata,
        output rdata,
        output ack,
        output line_irq
    );

    modport host (
        input pclk,
        input presetn,
        output req,
        output we,
        output addr,
        output wdata,
        input rdata,
        input ack,
        input line_irq
    );
endinterface

// File: canir_dev.sv
// Overview of operation
// - Select register: high enables, low flags
// - Module one to lines 0,3; two to 1,3
// - Enable byte masks sources onto line
// - Flags record events even when masked
// - CPU request needs three enables set
// - Transmit-ok raises status interrupt when enabled
// - Receive-ok set on any acknowledged frame
// - Error code update interrupts; 7 unused
// - Error warning at count 96 interrupts
// - Bus-off entry raises error interrupt
// - Object interrupts on enabled transmit/receive
// - Object pending bit set on request
// - Identifier: 0, object 1-32, or 8000h
// - Status highest; lower object number wins
// - Status read clears status interrupt
// - Pending stays until software clears it
// - One transmission may raise two requests
// - New data distinguishes receive from transmit
// - Transmit object interrupts on remote receive
// - Two interface sets reach all objects
// - Mask 7Fh transfer copies, clears pending, newdata
// - Software invalidates object before reconfiguring
// - Bus-off sets init, stops bus activity
`timescale 1ns/1ps
module canir_dev
    import canir_pkg::*;
#(
    parameter int NOBJ_P = NOBJ
)(
    canir_if.dev bus,
    input wire logic [NMOD-1:0] ev_tx_ok,
    input wire logic [NMOD-1:0][5:0] ev_tx_obj,
    input wire logic [NMOD-1:0] ev_rx_ack,
    input wire logic [NMOD-1:0][5:0] ev_rx_obj,
    input wire logic [NMOD-1:0] ev_lec_valid,
    input wire logic [NMOD-1:0][2:0] ev_lec,
    input wire logic [NMOD-1:0][8:0] tx_err_cnt,
    input wire logic [NMOD-1:0][8:0] rx_err_cnt,
    output logic [NMOD-1:0] bus_active
);

    if (NOBJ_P < 1 || NOBJ_P > NOBJ)
        $error("canir_dev: NOBJ_P out of range");

    function automatic logic [NOBJ_P-1:0] obj_hot(input logic [5:0] n);
        logic [NOBJ_P-1:0] h;
        h = '0;
        for (int i = 0; i < NOBJ_P; i++)
            h[i] = (n == 6'(i + 1));
        return h;
    endfunction

    // Lowest object number wins
    function automatic logic [15:0] first_id(input logic [NOBJ_P-1:0] p);
        logic [15:0] id;
        id = INTID_NONE;
        for (int i = NOBJ_P - 1; i >= 0; i--)
            if (p[i])
                id = 16'(i + 1);
        return id;
    endfunction

    logic [NMOD-1:0] mod_req;
    logic [NMOD-1:0] mod_req_q_r;
    logic [NMOD-1:0][15:0] mod_rd;
    logic [NLINE-1:0] line_nxt;
    logic [NLINE-1:0][15:0] sel_rd;
    logic [NLINE-1:0] line_r;
    logic [NLINE-1:0] lctl_r;
    logic [15:0] rdata_r;
    logic ack_r;
    logic [15:0] rd_mux;
    wire [3:0] idx = bus.addr[3:0];
    wire glob = bus.addr[A_GLOBAL];

    // ------------------------------------------------------------
    // Per-module interrupt sources
    // ------------------------------------------------------------
    for (genvar m = 0; m < NMOD; m++)
    begin : g_mod
        logic [15:0] ctrl_r;
        logic [15:0] stat_r;
        logic [15:0] stat_nxt;
        logic spend_r;
        logic ew_q_r;
        logic bo_q_r;
        logic [NOBJ_P-1:0] val_r, dir_r, object_tx_int_enable_r, object_rx_int_enable_r, pend_r, nd_r;
        logic [1:0][15:0] ifm_r;
        logic [1:0][15:0] ifd_r;
        logic [15:0] intid;

        wire sel = ~glob && bus.addr[A_MODSEL] == 1'(m);
        wire wr = bus.req & bus.we & sel;
        wire rd = bus.req & ~bus.we & sel;
        wire run = ~ctrl_r[C_INIT];
        wire [NOBJ_P-1:0] tx_hot =
            run & ev_tx_ok[m] ? obj_hot(ev_tx_obj[m]) & val_r : '0;
        wire [NOBJ_P-1:0] rx_hot =
            run & ev_rx_ack[m] ? obj_hot(ev_rx_obj[m]) & val_r : '0;
        wire transmit_ok_flag_ev = run & ev_tx_ok[m];
        wire receive_ok_flag_ev = run & ev_rx_ack[m];
        wire lec_ev = run & ev_lec_valid[m] & ev_lec[m] != LEC_UNUSED;
        wire ew = tx_err_cnt[m] >= ERR_WARN_LIMIT ||
                  rx_err_cnt[m] >= ERR_WARN_LIMIT;
        wire bo = tx_err_cnt[m] > BUS_OFF_FLAG_LIMIT;

        // Interface set transfer
        wire xfer = wr && (idx == R_IF1_REQ || idx == R_IF2_REQ);
        wire s = (idx == R_IF2_REQ);
        wire [15:0] xm = ifm_r[s];
        wire [15:0] xd = ifd_r[s];
        wire [NOBJ_P-1:0] xhot = xfer ? obj_hot(bus.wdata[5:0]) : '0;
        wire [NOBJ_P-1:0] wmask = xm[M_WR] & xm[M_CTRL] ? xhot : '0;
        wire [NOBJ_P-1:0] rmask = xm[M_WR] ? '0 : xhot;
        wire [NOBJ_P-1:0] pset = (tx_hot & object_tx_int_enable_r) | (rx_hot & object_rx_int_enable_r) |
                                 (wmask & {NOBJ_P{xd[O_PEND]}});
        wire [NOBJ_P-1:0] pclr = wmask | (xm[M_CLRPND] ? rmask : '0);
        wire [NOBJ_P-1:0] nset = rx_hot | (wmask & {NOBJ_P{xd[O_NEW_DATA_FLAG]}});
        wire [NOBJ_P-1:0] nclr = wmask | (xm[M_NEW_DATA_FLAG] ? rmask : '0);
        wire [4:0] ri = 5'(bus.wdata[5:0] - 6'h01);

        always_ff @(posedge bus.pclk or negedge bus.presetn)
        begin
            if (!bus.presetn)
            begin
                val_r <= '0;
                dir_r <= '0;
                object_tx_int_enable_r <= '0;
                object_rx_int_enable_r <= '0;
            end
            else
            begin
                val_r <= (val_r & ~wmask) | (wmask & {NOBJ_P{xd[O_VALID]}});
                dir_r <= (dir_r & ~wmask) | (wmask & {NOBJ_P{xd[O_DIR]}});
                object_tx_int_enable_r <= (object_tx_int_enable_r & ~wmask) | (wmask & {NOBJ_P{xd[O_OBJECT_TX_INT_ENABLE]}});
                object_rx_int_enable_r <= (object_rx_int_enable_r & ~wmask) | (wmask & {NOBJ_P{xd[O_OBJECT_RX_INT_ENABLE]}});
            end
        end

        // Set beats clear, so a frame racing the driver is not lost
        always_ff @(posedge bus.pclk or negedge bus.presetn)
        begin
            if (!bus.presetn)
            begin
                pend_r <= '0;
                nd_r <= '0;
            end
            else
            begin
                pend_r <= (pend_r & ~pclr) | pset;
                nd_r <= (nd_r & ~nclr) | nset;
            end
        end

        // Interface sets: mask, request, data
        always_ff @(posedge bus.pclk or negedge bus.presetn)
        begin
            if (!bus.presetn)
            begin
                ifm_r <= '0;
                ifd_r <= '0;
            end
            else if (wr)
            begin
                if (idx == R_IF1_MASK || idx == R_IF2_MASK)
                    ifm_r[idx == R_IF2_MASK] <= bus.wdata;
                else if (idx == R_IF1_DATA || idx == R_IF2_DATA)
                    ifd_r[idx == R_IF2_DATA] <= bus.wdata;
                else if (xfer && |rmask)
                begin
                    ifd_r[s] <= '0;
                    ifd_r[s][O_VALID] <= val_r[ri];
                    ifd_r[s][O_DIR] <= dir_r[ri];
                    ifd_r[s][O_OBJECT_TX_INT_ENABLE] <= object_tx_int_enable_r[ri];
                    ifd_r[s][O_OBJECT_RX_INT_ENABLE] <= object_rx_int_enable_r[ri];
                    ifd_r[s][O_PEND] <= pend_r[ri];
                    ifd_r[s][O_NEW_DATA_FLAG] <= nd_r[ri];
                end
            end
        end

        // Hardware status updates override a same-cycle write
        always_comb
        begin
            stat_nxt = stat_r;
            if (wr && idx == R_STAT)
                stat_nxt[S_RECEIVE_OK_FLAG:S_LEC] = bus.wdata[S_RECEIVE_OK_FLAG:S_LEC];
            if (transmit_ok_flag_ev)
                stat_nxt[S_TRANSMIT_OK_FLAG] = 1'b1;
            if (receive_ok_flag_ev)
                stat_nxt[S_RECEIVE_OK_FLAG] = 1'b1;
            if (lec_ev)
                stat_nxt[S_LEC +: 3] = ev_lec[m];
            stat_nxt[S_ERROR_WARNING_FLAG] = ew;
            stat_nxt[S_BUS_OFF_FLAG] = bo;
        end

        always_ff @(posedge bus.pclk or negedge bus.presetn)
        begin
            if (!bus.presetn)
            begin
                stat_r <= STAT_RST;
                ew_q_r <= 1'b0;
                bo_q_r <= 1'b0;
            end
            else
            begin
                stat_r <= stat_nxt;
                ew_q_r <= ew;
                bo_q_r <= bo;
            end
        end

        // Status/error pending, cleared by a status read
        always_ff @(posedge bus.pclk or negedge bus.presetn)
        begin
            if (!bus.presetn)
                spend_r <= 1'b0;
            else if ((ctrl_r[C_SIE] & (transmit_ok_flag_ev | receive_ok_flag_ev | lec_ev)) |
                     (ctrl_r[C_EIE] & ew & ~ew_q_r) |
                     (ctrl_r[C_EIE] & bo & ~bo_q_r))
                spend_r <= 1'b1;
            else if (rd && idx == R_STAT)
                spend_r <= 1'b0;
        end

        always_ff @(posedge bus.pclk or negedge bus.presetn)
        begin
            if (!bus.presetn)
                ctrl_r <= CTRL_RST;
            else
            begin
                if (wr && idx == R_CTRL)
                    ctrl_r <= {12'h000, bus.wdata[C_EIE:C_INIT]};
                if (bo & ~bo_q_r)
                    ctrl_r[C_INIT] <= 1'b1;
            end
        end

        assign intid = spend_r ? INTID_STATUS : first_id(pend_r);
        assign mod_req[m] = ctrl_r[C_IE] & (intid != INTID_NONE);
        assign bus_active[m] = ~ctrl_r[C_INIT];

        always_comb
        begin
            unique case (idx)
                R_CTRL: mod_rd[m] = ctrl_r;
                R_STAT: mod_rd[m] = stat_r;
                R_INTID: mod_rd[m] = intid;
                R_IF1_MASK: mod_rd[m] = ifm_r[0];
                R_IF1_DATA: mod_rd[m] = ifd_r[0];
                R_IF2_MASK: mod_rd[m] = ifm_r[1];
                R_IF2_DATA: mod_rd[m] = ifd_r[1];
                default: mod_rd[m] = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Source select registers and peripheral lines
    // ------------------------------------------------------------
    wire [NMOD-1:0] mod_rise = mod_req & ~mod_req_q_r;

    for (genvar l = 0; l < NLINE; l++)
    begin : g_line
        logic [7:0] en_r;
        logic [NMOD-1:0] fl_r;
        wire wsel = bus.req & bus.we & bus.addr == A_SEL0 + 7'(l);
        wire [NMOD-1:0] src = mod_rise & LINE_MAP[l];

        always_ff @(posedge bus.pclk or negedge bus.presetn)
        begin
            if (!bus.presetn)
            begin
                en_r <= SEL_RST[15:8];
                fl_r <= SEL_RST[NMOD-1:0];
            end
            else
            begin
                if (wsel)
                    en_r <= bus.wdata[15:SEL_EN];
                // Writing 0 clears a flag; a new event still wins
                fl_r <= (wsel ? fl_r & bus.wdata[NMOD-1:0] : fl_r) | src;
            end
        end

        assign sel_rd[l] = {en_r, {(8 - NMOD){1'b0}}, fl_r};
        assign line_nxt[l] = lctl_r[l] & |(en_r[NMOD-1:0] & fl_r);
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn)
    begin
        if (!bus.presetn)
        begin
            lctl_r <= '0;
            line_r <= '0;
            mod_req_q_r <= '0;
        end
        else
        begin
            if (bus.req && bus.we && bus.addr == A_LINE_CTRL)
                lctl_r <= bus.wdata[NLINE-1:0];
            line_r <= line_nxt;
            mod_req_q_r <= mod_req;
        end
    end

    // ------------------------------------------------------------
    // Local port answer, one cycle after the request
    // ------------------------------------------------------------
    always_comb
    begin
        rd_mux = 16'h0000;
        if (!glob)
            rd_mux = mod_rd[bus.addr[A_MODSEL]];
        else if (bus.addr == A_LINE_CTRL)
            rd_mux = {12'h000, lctl_r};
        else if (bus.addr[6:2] == A_SEL0[6:2])
            rd_mux = sel_rd[bus.addr[1:0]];
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn)
    begin
        if (!bus.presetn)
        begin
            ack_r <= 1'b0;
            rdata_r <= 16'h0000;
        end
        else
        begin
            ack_r <= bus.req;
            if (bus.req && !bus.we)
                rdata_r <= rd_mux;
        end
    end

    assign bus.ack = ack_r;
    assign bus.rdata = rdata_r;
    assign bus.line_irq = line_r;

endmodule // canir_dev

// File: canir_host.sv
`timescale 1ns/1ps
module canir_host
    import canir_pkg::*;
(
    canir_if.host bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [NLINE-1:0] cpu_irq
);

    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [NLINE-1:0] irq_r;
    logic [AW-1:0] addr_r;
    logic we_r;
    logic [DW-1:0] wdata_r;
    logic [DW-1:0] rdata_r;
    logic req_r;
    logic busy_r;
    logic [31:0] rd_mux;
    logic map_ok;

    wire setup = psel & ~penable;
    // Write lands at the access edge where pready is sampled high
    wire acc_wr = psel & penable & pready_r & pwrite;

    // ------------------------------------------------------------
    // APB slave: one wait-free access phase
    // ------------------------------------------------------------
    always_comb
    begin
        map_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            H_CMD: rd_mux = {23'h000000, we_r, 1'b0, addr_r};
            H_WDATA: rd_mux = {16'h0000, wdata_r};
            H_RDATA: rd_mux = {16'h0000, rdata_r};
            H_STAT: rd_mux = {31'h00000000, busy_r};
            H_LINES: rd_mux = {28'h0000000, irq_r};
            default: map_ok = 1'b0;
        endcase
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn)
    begin
        if (!bus.presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup & ~map_ok;
            if (setup && !pwrite)
                prdata_r <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Command to the device port
    // ------------------------------------------------------------
    always_ff @(posedge bus.pclk or negedge bus.presetn)
    begin
        if (!bus.presetn)
        begin
            addr_r <= '0;
            we_r <= 1'b0;
            wdata_r <= '0;
            req_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else
        begin
            req_r <= 1'b0;
            if (acc_wr && paddr == H_WDATA)
                wdata_r <= pwdata[DW-1:0];
            // A new command while busy is dropped
            if (acc_wr && paddr == H_CMD && !busy_r)
            begin
                addr_r <= pwdata[AW-1:0];
                we_r <= pwdata[H_CMD_WR];
                req_r <= 1'b1;
                busy_r <= 1'b1;
            end
            else if (bus.ack)
                busy_r <= 1'b0;
        end
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn)
    begin
        if (!bus.presetn)
        begin
            rdata_r <= '0;
            irq_r <= '0;
        end
        else
        begin
            if (bus.ack && !we_r)
                rdata_r <= bus.rdata;
            irq_r <= bus.line_irq;
        end
    end

    assign bus.req = req_r;
    assign bus.we = we_r;
    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign cpu_irq = irq_r;

endmodule // canir_host

// File: canir_props.sv
`timescale 1ns/1ps
module canir_props
    import canir_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic [DW-1:0] rdata,
    input wire logic ack,
    input wire logic [NLINE-1:0] line_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Line enable shadow
    // ----------------------------------------
    // Two stages: a line may lag its enable by one registered cycle
    logic [NLINE-1:0] len_r;
    logic [NLINE-1:0] len_d_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            len_r <= '0;
            len_d_r <= '0;
        end
        else
        begin
            if (req && we && addr == A_LINE_CTRL)
                len_r <= wdata[NLINE-1:0];
            len_d_r <= len_r;
        end
    end

    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    sequence s_rd_intid;
        req && !we && !addr[6] && addr[3:0] == R_INTID ##1 ack;
    endsequence
    sequence s_rd_sel;
        req && !we && addr >= A_SEL0 && addr < A_LINE_CTRL ##1 ack;
    endsequence

    a_ack_follows_req:
        assert property (req |=> ack) else $error("no ack after req");
    a_ack_has_cause:
        assert property (ack |-> $past(req)) else $error("stray ack");
    a_req_spacing:
        assert property (req |=> !req) else $error("req too close");
    a_rdata_hold:
        assert property (!ack |-> $stable(rdata))
        else $error("rdata moved without ack");
    a_line_two_idle:
        assert property (line_irq[2] == 1'b0) else $error("line 2 raised");
    a_line_gated:
        assert property ((line_irq & ~len_r & ~len_d_r) == '0)
        else $error("line raised while disabled");
    a_intid_legal:
        assert property (s_rd_intid |-> rdata == INTID_NONE
            || rdata == INTID_STATUS
            || (rdata >= 16'h0001 && rdata <= 16'h0020))
        else $error("illegal identifier");
    a_sel_flag_bits:
        assert property (s_rd_sel |-> rdata[7:2] == 6'h00)
        else $error("unused flag bits set");
endmodule // canir_props

// File: can_interrupt_source_routing_tb.sv
`timescale 1ns/1ps
module can_interrupt_source_routing_tb
    import canir_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr;
    logic [NLINE-1:0] cpu_irq;
    logic [NMOD-1:0] ev_tx_ok = '0, ev_rx_ack = '0, ev_lec_valid = '0;
    logic [NMOD-1:0] bus_active;
    logic [NMOD-1:0][5:0] ev_obj = '0;
    logic [NMOD-1:0][2:0] ev_lec = '0;
    logic [NMOD-1:0][8:0] tx_err_cnt = '0, rx_err_cnt = '0;
    int num_errors = 0, num_checks = 0, cyc = 0;

    always #4 pclk = ~pclk;
    canir_if canir_if_inst (.pclk(pclk), .presetn(presetn));
    canir_host canir_host_inst (.bus(canir_if_inst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_irq(cpu_irq));
    canir_dev canir_dev_inst (.bus(canir_if_inst), .ev_tx_ok(ev_tx_ok),
        .ev_tx_obj(ev_obj), .ev_rx_ack(ev_rx_ack), .ev_rx_obj(ev_obj),
        .ev_lec_valid(ev_lec_valid), .ev_lec(ev_lec),
        .tx_err_cnt(tx_err_cnt), .rx_err_cnt(rx_err_cnt),
        .bus_active(bus_active));
    canir_props canir_props_inst (.pclk(pclk), .presetn(presetn),
        .req(canir_if_inst.req), .we(canir_if_inst.we),
        .addr(canir_if_inst.addr), .wdata(canir_if_inst.wdata),
        .rdata(canir_if_inst.rdata), .ack(canir_if_inst.ack),
        .line_irq(canir_if_inst.line_irq));

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait limit here; a stuck slave is caught by the timeout
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Busy poll has no limit of its own; the timeout ends a hang
    task automatic wait_idle();
        do apb(1'b0, H_STAT, '0); while (q[0] !== 1'b0);
    endtask

    task automatic dw(input logic [6:0] a, input logic [15:0] d);
        apb(1'b1, H_WDATA, {16'h0000, d});
        apb(1'b1, H_CMD, {23'h000000, 2'h2, a});
        wait_idle();
    endtask

    task automatic dr(input logic [6:0] a);
        apb(1'b1, H_CMD, {25'h0000000, a});
        wait_idle();
        apb(1'b0, H_RDATA, '0);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            num_errors++;
        end
    endtask

    task automatic pulse(input int m, input logic tx, input logic rx,
                         input logic [5:0] obj, input logic [2:0] last_error_code);
        @(posedge pclk);
        ev_tx_ok[m] <= tx;
        ev_rx_ack[m] <= rx;
        ev_lec_valid[m] <= (last_error_code != 3'h0);
        ev_obj[m] <= obj;
        ev_lec[m] <= last_error_code;
        @(posedge pclk);
        ev_tx_ok <= '0;
        ev_rx_ack <= '0;
        ev_lec_valid <= '0;
        repeat (8) @(posedge pclk);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Timeout
    // ----------------------------------------
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            summarize();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        dr(7'h00); chk(q[15:0], CTRL_RST);
        chk(bus_active, 2'h0);
        dr(7'h02); chk(q[15:0], INTID_NONE);
        dr(A_SEL0); chk(q[15:0], SEL_RST);
        apb(1'b0, 12'h7FC, '0); chk(slv, 1'b1);
        dw(7'h00, 16'h000E);
        dw(7'h10, 16'h0006);
        chk(bus_active, 2'h3);
        dw(7'h40, 16'h0100);
        dw(7'h41, 16'h0200);
        dw(7'h43, 16'h0000);
        dw(A_LINE_CTRL, 16'h000F);
        for (int o = 3; o <= 5; o += 2)
        begin
            dw(7'h08, 16'h000D);
            dw(7'h06, 16'h0090);
            dw(7'h07, o[15:0]);
        end
        pulse(0, 1'b1, 1'b0, 6'd5, 3'h0);
        chk(cpu_irq, 4'h1);
        dr(7'h43); chk(q[1:0], 2'h1);
        dr(7'h02); chk(q[15:0], INTID_STATUS);
        dr(7'h01); chk(q[4:3], 2'h1);
        dr(7'h02); chk(q[15:0], 16'h0005);
        pulse(0, 1'b0, 1'b1, 6'd3, 3'h0);
        dr(7'h01);
        dr(7'h02); chk(q[15:0], 16'h0003);
        dw(7'h03, 16'h007F);
        dw(7'h04, 16'h0003);
        dr(7'h05); chk(q[5:4], 2'h3);
        dr(7'h02); chk(q[15:0], 16'h0005);
        dw(7'h04, 16'h0005);
        dr(7'h05); chk(q[5:4], 2'h1);
        dr(7'h02); chk(q[15:0], INTID_NONE);
        dw(7'h40, 16'h0100);
        repeat (6) @(posedge pclk);
        chk(cpu_irq, 4'h0);
        pulse(1, 1'b1, 1'b0, 6'd0, 3'h0);
        chk(cpu_irq, 4'h2);
        dr(7'h11);
        dw(7'h01, {13'h0000, LEC_UNUSED});
        pulse(0, 1'b0, 1'b1, 6'd0, 3'h0);
        dr(7'h01); chk(q[4:0], 5'h17);
        pulse(0, 1'b0, 1'b0, 6'd0, 3'h3);
        dr(7'h02); chk(q[15:0], INTID_STATUS);
        dr(7'h01); chk(q[2:0], 3'h3);
        tx_err_cnt[0] <= 9'd96;
        repeat (8) @(posedge pclk);
        dr(7'h02); chk(q[15:0], INTID_STATUS);
        dr(7'h01); chk(q[6:5], 2'h1);
        tx_err_cnt[0] <= 9'd256;
        repeat (8) @(posedge pclk);
        dr(7'h02); chk(q[15:0], INTID_STATUS);
        chk(bus_active, 2'h2);
        summarize();
    end
endmodule // can_interrupt_source_routing_tb
